// File: input_reference_selector.v
// Reference input selector for one loop: policy, fault masks, ranks, history and fast lock.
// Assumes LOS_I/OOF_I come from asynchronous monitors and an AXI4-Lite master on CLK_I.
//
// Our own choice: the AXI4-Lite slave port.
`include "input_reference_selector_regs.vh"
`default_nettype none

module input_reference_selector #(
  parameter integer NUM_INPUTS = 4,
  parameter integer HIST_CYCLES = `HIST_CYCLES_DEF,
  parameter integer WIDE_CYCLES = `WIDE_CYCLES_DEF
) (
  // Clock, reset, enable
  input wire CLK_I,
  input wire SYS_RST_I,
  input wire CE_I,
  // Input fault monitors (asynchronous)
  input wire [3:0] LOS_I,
  input wire [3:0] OOF_I,
  // AXI4-Lite write address, data and response
  input wire [15:0] AWADDR_I,
  input wire AWVALID_I,
  output wire AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output wire WREADY_O,
  output wire [1:0] BRESP_O,
  output wire BVALID_O,
  input wire BREADY_I,
  // AXI4-Lite read
  input wire [15:0] ARADDR_I,
  input wire ARVALID_I,
  output wire ARREADY_O,
  output wire [31:0] RDATA_O,
  output wire [1:0] RRESP_O,
  output wire RVALID_O,
  input wire RREADY_I,
  // Loop control
  output wire [1:0] SEL_INPUT_O,
  output wire TRACKING_O,
  output wire HOLDOVER_O,
  output wire FREE_RUN_O,
  output wire HISTORY_GOOD_O,
  output wire WIDE_LOOP_O,
  output wire BUILDOUT_O,
  output wire [9:0] PHASE_LIMIT_O
);

  localparam [12:0] HIST_MAX = HIST_CYCLES[12:0];
  localparam [12:0] WIDE_MAX = WIDE_CYCLES[12:0];

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] hold_ctrl_reg, policy_reg, masks_reg, rank_low_reg, rank_high_reg;
  reg [7:0] variant_reg, limit_low_reg, limit_high_reg, coarse_len_reg, coarse_dly_reg;
  reg [7:0] spare_reg, fine_len_reg, manual_sel_reg;

  // Bus state
  reg awready_reg, wready_reg, bvalid_reg, wstrb0_reg, arready_reg, rvalid_reg;
  reg [1:0] bresp_reg, rresp_reg;
  reg [13:0] waddr_reg;
  reg [7:0] wdata_reg;
  reg [31:0] rdata_reg;

  // Selector and loop state
  reg [3:0] los_meta_reg, los_sync_reg, oof_meta_reg, oof_sync_reg;
  reg [1:0] sel_reg;
  reg tracking_reg, holdover_reg, free_run_reg, hist_good_reg, wide_reg, buildout_reg;
  reg [12:0] hist_cnt_reg, wide_cnt_reg;
  reg [6:0] bo_cnt_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Input qualification per input
  wire [3:0] valid;
  wire [3:0] cand;
  wire [11:0] rank_flat;
  wire [15:0] rank_word = {rank_high_reg, rank_low_reg};

  genvar g;
  generate
    for (g = 0; g < NUM_INPUTS; g = g + 1) begin : qual
      assign rank_flat[g*3 +: 3] = rank_word[g*4 +: 3];
      assign valid[g] = ~(los_sync_reg[g] & ~masks_reg[g]) & ~(oof_sync_reg[g] & ~masks_reg[g+4]);
      assign cand[g] = valid[g] && (rank_word[g*4 +: 3] != 3'h0) && (rank_word[g*4 +: 3] < 3'h5);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Best candidate
  reg [2:0] best_rank;
  reg [1:0] best_idx;
  reg found;
  integer k;

  always @* begin
    best_rank = 3'h7;
    best_idx = 2'h0;
    found = 1'b0;
    // strict less keeps lowest index on ties
    for (k = 0; k < NUM_INPUTS; k = k + 1) begin
      if (cand[k] && (rank_flat[k*3 +: 3] < best_rank)) begin
        best_rank = rank_flat[k*3 +: 3];
        best_idx = k[1:0];
        found = 1'b1;
      end
    end
  end

  wire [1:0] policy = policy_reg[`POLICY_MSB:`POLICY_LSB];
  wire auto_mode = (policy == `POLICY_AUTO_HOLD) || (policy == `POLICY_AUTO_REVERT);
  wire [1:0] manual_sel = manual_sel_reg[1:0];
  reg [1:0] sel_next;
  reg usable;

  always @* begin
    sel_next = sel_reg;
    usable = 1'b0;
    if (!auto_mode) begin
      // manual and reserved policy follow software choice
      sel_next = manual_sel;
      usable = ~los_sync_reg[manual_sel];
    end else if ((policy == `POLICY_AUTO_HOLD) && cand[sel_reg]) begin
      sel_next = sel_reg;
      usable = 1'b1;
    end else if (found) begin
      sel_next = best_idx;
      usable = 1'b1;
    end
  end

  wire track_next = usable & ~hold_ctrl_reg[`HOLD_REQUEST_BIT];
  wire switch_evt = track_next & tracking_reg & (sel_next != sel_reg);
  wire enter_evt = track_next & ~tracking_reg;
  // buildout window from measurement lengths
  // Seven bits hold the largest sum of all three lengths without wrapping
  wire [6:0] bo_len = {2'b00, coarse_len_reg[4:0]} + {2'b00, coarse_dly_reg[4:0]}
                      + {3'b000, fine_len_reg[3:0]};

  //////////////////////////////////////////////////////////////////////////////
  // Selector and loop state
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      los_meta_reg <= 4'h0;
      los_sync_reg <= 4'h0;
      oof_meta_reg <= 4'h0;
      oof_sync_reg <= 4'h0;
      sel_reg <= 2'h0;
      tracking_reg <= 1'b0;
      holdover_reg <= 1'b0;
      free_run_reg <= 1'b1;
      hist_cnt_reg <= 13'h0000;
      hist_good_reg <= 1'b0;
      wide_cnt_reg <= 13'h0000;
      wide_reg <= 1'b0;
      bo_cnt_reg <= 7'h00;
      buildout_reg <= 1'b0;
    end else if (CE_I) begin
      los_meta_reg <= LOS_I;
      los_sync_reg <= los_meta_reg;
      oof_meta_reg <= OOF_I;
      oof_sync_reg <= oof_meta_reg;
      sel_reg <= sel_next;
      tracking_reg <= track_next;
      // no usable reference: holdover with history, else free-run
      holdover_reg <= ~track_next & hist_good_reg;
      free_run_reg <= ~track_next & ~hist_good_reg;
      if (enter_evt || switch_evt) begin
        // fresh history on entering tracking, same reference included, or on a switch
        hist_cnt_reg <= 13'h0000;
        hist_good_reg <= 1'b0;
      end else if (tracking_reg && track_next && (hist_cnt_reg != HIST_MAX)) begin
        hist_cnt_reg <= hist_cnt_reg + 13'h0001;
        hist_good_reg <= (hist_cnt_reg + 13'h0001) == HIST_MAX;
      end
      // wide loop after leaving holdover or free-run
      if (enter_evt) begin
        wide_cnt_reg <= WIDE_MAX;
        wide_reg <= 1'b1;
      end else if (!track_next) begin
        wide_cnt_reg <= 13'h0000;
        wide_reg <= 1'b0;
      end else if (wide_cnt_reg != 13'h0000) begin
        wide_cnt_reg <= wide_cnt_reg - 13'h0001;
        wide_reg <= wide_cnt_reg != 13'h0001;
      end
      if (switch_evt && policy_reg[`GLITCHLESS_EN_BIT]) begin
        bo_cnt_reg <= bo_len;
        buildout_reg <= 1'b1;
      end else if (!track_next || (bo_cnt_reg == 7'h00)) begin
        bo_cnt_reg <= 7'h00;
        buildout_reg <= 1'b0;
      end else begin
        bo_cnt_reg <= bo_cnt_reg - 7'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      waddr_reg <= 14'h0000;
      wdata_reg <= `RST_ZERO;
      wstrb0_reg <= 1'b0;
      hold_ctrl_reg <= `RST_ZERO;
      policy_reg <= `RST_ZERO;
      masks_reg <= `RST_ZERO;
      rank_low_reg <= `RST_ZERO;
      rank_high_reg <= `RST_ZERO;
      variant_reg <= `RST_VARIANT;
      limit_low_reg <= `RST_ZERO;
      limit_high_reg <= `RST_ZERO;
      coarse_len_reg <= `RST_ZERO;
      coarse_dly_reg <= `RST_ZERO;
      spare_reg <= `RST_ZERO;
      fine_len_reg <= `RST_ZERO;
      manual_sel_reg <= `RST_ZERO;
    end else if (CE_I) begin
      if (AWVALID_I && awready_reg) begin
        awready_reg <= 1'b0;
        waddr_reg <= AWADDR_I[15:2];
      end
      if (WVALID_I && wready_reg) begin
        wready_reg <= 1'b0;
        wdata_reg <= WDATA_I[7:0];
        wstrb0_reg <= WSTRB_I[0];
      end
      if (!awready_reg && !wready_reg && !bvalid_reg) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= `RESP_OKAY;
        case (waddr_reg)
          `IDX_HOLD_CTRL: if (wstrb0_reg) hold_ctrl_reg <= wdata_reg & `MASK_HOLD_CTRL;
          `IDX_SWITCH_POLICY_CTRL: if (wstrb0_reg) policy_reg <= wdata_reg & `MASK_SWITCH_POLICY;
          `IDX_INPUT_FAULT_MASKS: if (wstrb0_reg) masks_reg <= wdata_reg;
          `IDX_INPUT_RANK_LOW: if (wstrb0_reg) rank_low_reg <= wdata_reg & `MASK_RANK;
          `IDX_INPUT_RANK_HIGH: if (wstrb0_reg) rank_high_reg <= wdata_reg & `MASK_RANK;
          // low four bits stored as written; software keeps them at defaults
          `IDX_GLITCHLESS_SWITCH_VARIANT: if (wstrb0_reg) variant_reg <= wdata_reg & `MASK_VARIANT;
          `IDX_PHASE_LIMIT_LOW: if (wstrb0_reg) limit_low_reg <= wdata_reg;
          `IDX_PHASE_LIMIT_HIGH: if (wstrb0_reg) limit_high_reg <= wdata_reg & `MASK_LIMIT_HIGH;
          `IDX_COARSE_MEASURE_LENGTH: if (wstrb0_reg) coarse_len_reg <= wdata_reg & `MASK_COARSE;
          `IDX_COARSE_MEASURE_DELAY: if (wstrb0_reg) coarse_dly_reg <= wdata_reg & `MASK_COARSE;
          `IDX_HISTORY_AND_LOCK_STATE: bresp_reg <= `RESP_OKAY;
          `IDX_SPARE_CONTROL: if (wstrb0_reg) spare_reg <= wdata_reg;
          `IDX_FINE_MEASURE_LENGTH: if (wstrb0_reg) fine_len_reg <= wdata_reg & `MASK_FINE;
          `IDX_MANUAL_SELECT: if (wstrb0_reg) manual_sel_reg <= wdata_reg & `MASK_MANUAL;
          `IDX_SELECTOR_STATUS: bresp_reg <= `RESP_OKAY;
          default: bresp_reg <= `RESP_SLVERR;
        endcase
      end
      // Readies come back only after the response, so one write is in flight
      if (bvalid_reg && BREADY_I) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  reg [7:0] rd_byte;
  reg rd_hit;

  always @* begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (ARADDR_I[15:2])
      `IDX_HOLD_CTRL: rd_byte = hold_ctrl_reg;
      `IDX_SWITCH_POLICY_CTRL: rd_byte = policy_reg;
      `IDX_INPUT_FAULT_MASKS: rd_byte = masks_reg;
      `IDX_INPUT_RANK_LOW: rd_byte = rank_low_reg;
      `IDX_INPUT_RANK_HIGH: rd_byte = rank_high_reg;
      `IDX_GLITCHLESS_SWITCH_VARIANT: rd_byte = variant_reg;
      `IDX_PHASE_LIMIT_LOW: rd_byte = limit_low_reg;
      `IDX_PHASE_LIMIT_HIGH: rd_byte = limit_high_reg;
      `IDX_COARSE_MEASURE_LENGTH: rd_byte = coarse_len_reg;
      `IDX_COARSE_MEASURE_DELAY: rd_byte = coarse_dly_reg;
      `IDX_HISTORY_AND_LOCK_STATE: rd_byte = {5'h00, wide_reg, hist_good_reg, 1'b0};
      `IDX_SPARE_CONTROL: rd_byte = spare_reg;
      `IDX_FINE_MEASURE_LENGTH: rd_byte = fine_len_reg;
      `IDX_MANUAL_SELECT: rd_byte = manual_sel_reg;
      `IDX_SELECTOR_STATUS: rd_byte = {1'b0, buildout_reg, free_run_reg, holdover_reg,
                                       tracking_reg, found, sel_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (CE_I) begin
      if (ARVALID_I && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= {24'h000000, rd_byte};
        rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_reg && RREADY_I) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign AWREADY_O = awready_reg;
  assign WREADY_O = wready_reg;
  assign BVALID_O = bvalid_reg;
  assign BRESP_O = bresp_reg;
  assign ARREADY_O = arready_reg;
  assign RVALID_O = rvalid_reg;
  assign RRESP_O = rresp_reg;
  assign RDATA_O = rdata_reg;
  assign SEL_INPUT_O = sel_reg;
  assign TRACKING_O = tracking_reg;
  assign HOLDOVER_O = holdover_reg;
  assign FREE_RUN_O = free_run_reg;
  assign HISTORY_GOOD_O = hist_good_reg;
  assign WIDE_LOOP_O = wide_reg;
  assign BUILDOUT_O = buildout_reg;
  // limit handed to the phase comparator
  assign PHASE_LIMIT_O = {limit_high_reg[1:0], limit_low_reg};

endmodule // input_reference_selector

`default_nettype wire

// File: input_reference_selector_monitor.sv
// Checker for loop state, history, fast lock and buildout of the selector.
// Assumes it is bound to input_reference_selector with CE_I held high.
`default_nettype none
module input_reference_selector_monitor #(
  parameter integer WIDE_CYCLES = 256
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic BVALID_O,
  input wire logic [1:0] SEL_INPUT_O,
  input wire logic TRACKING_O,
  input wire logic HOLDOVER_O,
  input wire logic FREE_RUN_O,
  input wire logic HISTORY_GOOD_O,
  input wire logic WIDE_LOOP_O,
  input wire logic BUILDOUT_O,
  input wire logic [9:0] PHASE_LIMIT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] sel_d1_reg;
  logic [15:0] wide_run_reg;
  default clocking dcb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sel_d1_reg <= 2'h0;
      wide_run_reg <= 16'h0000;
    end else begin
      sel_d1_reg <= SEL_INPUT_O;
      wide_run_reg <= WIDE_LOOP_O ? wide_run_reg + 16'h0001 : 16'h0000;
    end
  end
  a_state_onehot: assert property ($onehot({TRACKING_O, HOLDOVER_O, FREE_RUN_O}))
    else $error("loop state not one-hot");
  a_mode_by_history: assert property (!TRACKING_O && $stable(HISTORY_GOOD_O) |->
    HOLDOVER_O == HISTORY_GOOD_O) else $error("holdover disagrees with history flag");
  a_hist_frozen: assert property (!$past(TRACKING_O) && !TRACKING_O |->
    $stable(HISTORY_GOOD_O)) else $error("history moved while not tracking");
  a_hist_cleared: assert property ($rose(TRACKING_O) |=> !HISTORY_GOOD_O)
    else $error("history not cleared on new reference");
  a_wide_in_track: assert property (WIDE_LOOP_O |-> TRACKING_O || $past(TRACKING_O))
    else $error("wide loop without tracking");
  a_wide_bounded: assert property (WIDE_LOOP_O |-> wide_run_reg < 16'(WIDE_CYCLES))
    else $error("wide loop held too long");
  a_limit_on_write: assert property ($changed(PHASE_LIMIT_O) |-> $rose(BVALID_O))
    else $error("phase limit changed without a write");
  // Buildout starts at the very edge that moves the selection
  a_buildout_switch: assert property ($rose(BUILDOUT_O) |-> SEL_INPUT_O != sel_d1_reg)
    else $error("buildout without input change");
  cover property ($rose(HOLDOVER_O));
  cover property ($rose(BUILDOUT_O));
  cover property ($fell(WIDE_LOOP_O) && TRACKING_O);
endmodule // input_reference_selector_monitor
bind input_reference_selector input_reference_selector_monitor #(.WIDE_CYCLES(WIDE_CYCLES))
  i_input_reference_selector_monitor (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .BVALID_O(BVALID_O), .SEL_INPUT_O(SEL_INPUT_O), .TRACKING_O(TRACKING_O),
  .HOLDOVER_O(HOLDOVER_O), .FREE_RUN_O(FREE_RUN_O), .HISTORY_GOOD_O(HISTORY_GOOD_O),
  .WIDE_LOOP_O(WIDE_LOOP_O), .BUILDOUT_O(BUILDOUT_O), .PHASE_LIMIT_O(PHASE_LIMIT_O));
`default_nettype wire

// File: input_reference_selector_regs.vh
// Register indices, field positions, reset values and counts for the reference selector.
// Assumes byte address = 4 * index on a 32-bit AXI4-Lite bus.
`ifndef INPUT_REFERENCE_SELECTOR_REGS_VH
`define INPUT_REFERENCE_SELECTOR_REGS_VH

// Register indices
`define IDX_HOLD_CTRL 14'h0535
`define IDX_SWITCH_POLICY_CTRL 14'h0536
`define IDX_INPUT_FAULT_MASKS 14'h0537
`define IDX_INPUT_RANK_LOW 14'h0538
`define IDX_INPUT_RANK_HIGH 14'h0539
`define IDX_GLITCHLESS_SWITCH_VARIANT 14'h053A
`define IDX_PHASE_LIMIT_LOW 14'h053B
`define IDX_PHASE_LIMIT_HIGH 14'h053C
`define IDX_COARSE_MEASURE_LENGTH 14'h053D
`define IDX_COARSE_MEASURE_DELAY 14'h053E
`define IDX_HISTORY_AND_LOCK_STATE 14'h053F
`define IDX_SPARE_CONTROL 14'h0540
`define IDX_FINE_MEASURE_LENGTH 14'h0588
`define IDX_MANUAL_SELECT 14'h05F0
`define IDX_SELECTOR_STATUS 14'h05F1

// Field positions
`define POLICY_MSB 1
`define POLICY_LSB 0
`define GLITCHLESS_EN_BIT 2
`define HOLD_REQUEST_BIT 0
`define HISTORY_GOOD_BIT 1
`define WIDE_LOOP_BIT 2

// Field masks (reserved bits read zero)
`define MASK_SWITCH_POLICY 8'h07
`define MASK_HOLD_CTRL 8'h01
`define MASK_RANK 8'h77
`define MASK_VARIANT 8'h0F
`define MASK_LIMIT_HIGH 8'h03
`define MASK_COARSE 8'h1F
`define MASK_FINE 8'h0F
`define MASK_MANUAL 8'h03

// Policy encodings
`define POLICY_MANUAL 2'h0
`define POLICY_AUTO_HOLD 2'h1
`define POLICY_AUTO_REVERT 2'h2

// Reset values
`define RST_ZERO 8'h00
`define RST_VARIANT 8'h01

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Default counts in CLK_I cycles
`define HIST_CYCLES_DEF 4096
`define WIDE_CYCLES_DEF 256

`endif

// File: ref_clock_model.sv
// Four reference inputs with loss and frequency-offset monitors.
// Assumes the bench names the faulty inputs; flags follow one clock later.
`default_nettype none
module ref_clock_model (
  // Clock
  input wire logic clk_i,
  // Requested faults
  input wire logic [3:0] loss_req_i,
  input wire logic [3:0] offset_req_i,
  // Monitor flags, high on fault
  output logic [3:0] los_o,
  output logic [3:0] oof_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Flags are unknown until the first edge; the selector is still in reset then
  always @(posedge clk_i) begin
    los_o <= loss_req_i;
    oof_o <= offset_req_i;
  end
endmodule // ref_clock_model
`default_nettype wire

// File: tb_top.sv
// Bench: AXI4-Lite register tasks and reference selection scenarios.
// Assumes the register header is on the include path; CE_I stays high.
`include "input_reference_selector_regs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [15:0] aw_addr = 16'h0000, ar_addr = 16'h0000;
  logic [31:0] w_data = 32'h00000000, r_data;
  logic [3:0] loss = 4'hF, offs = 4'h0, signal_loss, frequency_offset_fault;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, trk, hov, frun, hgood, wide, bout;
  logic [1:0] b_resp, r_resp, sel;
  logic [9:0] plim;
  int mismatches = 0, samples_checked = 0, wcnt, bcnt;
  logic [13:0] tidx [14] = '{14'h0535, 14'h0536, 14'h0537, 14'h0538, 14'h0539, 14'h053A,
    14'h053B, 14'h053C, 14'h053D, 14'h053E, 14'h053F, 14'h0540, 14'h0588, 14'h05F0};
  logic [7:0] tmsk [14] = '{8'h01, 8'h07, 8'hFF, 8'h77, 8'h77, 8'h01, 8'hFF, 8'h03, 8'h1F,
    8'h1F, 8'h00, 8'hFF, 8'h0F, 8'h03};
  ref_clock_model i_ref_clock_model (.clk_i(clk), .loss_req_i(loss), .offset_req_i(offs),
    .los_o(signal_loss), .oof_o(frequency_offset_fault));
  // Short history and fast-lock counts keep the run brief
  input_reference_selector #(.HIST_CYCLES(16), .WIDE_CYCLES(8)) i_input_reference_selector (
    .CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .LOS_I(signal_loss), .OOF_I(frequency_offset_fault),
    .AWADDR_I(aw_addr), .AWVALID_I(aw_v), .AWREADY_O(aw_rdy), .WDATA_I(w_data),
    .WSTRB_I(4'hF), .WVALID_I(w_v), .WREADY_O(w_rdy), .BRESP_O(b_resp), .BVALID_O(b_v),
    .BREADY_I(b_r), .ARADDR_I(ar_addr), .ARVALID_I(ar_v), .ARREADY_O(ar_rdy),
    .RDATA_O(r_data), .RRESP_O(r_resp), .RVALID_O(r_v), .RREADY_I(r_r),
    .SEL_INPUT_O(sel), .TRACKING_O(trk), .HOLDOVER_O(hov), .FREE_RUN_O(frun),
    .HISTORY_GOOD_O(hgood), .WIDE_LOOP_O(wide), .BUILDOUT_O(bout), .PHASE_LIMIT_O(plim));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [1:0] s, input logic t, input logic h, input logic f);
    chk(32'({sel, trk, hov, frun}), 32'({s, t, h, f}));
  endtask
  task automatic wr(input logic [13:0] i, input logic [7:0] d, input logic [1:0] er);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk);
    aw_addr <= {i, 2'h0};
    w_data <= {24'h000000, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && aw_rdy === 1'b1) begin
        ad = 1'b1;
        aw_v <= 1'b0;
      end
      if (!dd && w_rdy === 1'b1) begin
        dd = 1'b1;
        w_v <= 1'b0;
      end
    end
    do @(posedge clk); while (b_v !== 1'b1);
    b_r <= 1'b0;
    chk(32'(b_resp), 32'(er));
  endtask
  task automatic rd(input logic [13:0] i, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    ar_addr <= {i, 2'h0};
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do @(posedge clk); while (ar_rdy !== 1'b1);
    ar_v <= 1'b0;
    do @(posedge clk); while (r_v !== 1'b1);
    r_r <= 1'b0;
    chk(r_data, ed);
    chk(32'(r_resp), 32'(er));
  endtask
  task automatic watch(input int n);
    wcnt = 0;
    bcnt = 0;
    repeat (n) begin
      @(posedge clk);
      wcnt += int'(wide === 1'b1);
      bcnt += int'(bout === 1'b1);
    end
  endtask
  task automatic fault(input logic [3:0] l, input logic [3:0] o);
    @(posedge clk);
    loss <= l;
    offs <= o;
    watch(30);
  endtask
  initial begin
    #60000;
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 14; k++) rd(tidx[k], (k == 5) ? 32'h1 : 32'h0, `RESP_OKAY);
    rd(`IDX_SELECTOR_STATUS, 32'h20, `RESP_OKAY);
    for (int k = 0; k < 14; k++) wr(tidx[k], (k == 5) ? 8'h01 : 8'hFF, `RESP_OKAY);
    for (int k = 0; k < 14; k++) rd(tidx[k], 32'(tmsk[k]), `RESP_OKAY);
    chk(32'(plim), 32'h3FF);
    for (int k = 0; k < 14; k++) wr(tidx[k], (k == 5) ? 8'h01 : 8'h00, `RESP_OKAY);
    wr(14'h0541, 8'hFF, `RESP_SLVERR);
    rd(14'h0541, 32'h0, `RESP_SLVERR);
    ////////////////////////////////////////////////////////////////////////////////
    wr(`IDX_MANUAL_SELECT, 8'h02, `RESP_OKAY);
    wr(`IDX_INPUT_FAULT_MASKS, 8'h44, `RESP_OKAY);
    fault(4'hB, 4'h0);
    st(2'h2, 1'b1, 1'b0, 1'b0);
    chk(32'(wcnt), 32'd8);
    chk(32'(hgood), 32'h1);
    wr(`IDX_HOLD_CTRL, 8'h01, `RESP_OKAY);
    watch(3);
    st(2'h2, 1'b0, 1'b1, 1'b0);
    rd(`IDX_HISTORY_AND_LOCK_STATE, 32'h02, `RESP_OKAY);
    wr(`IDX_HOLD_CTRL, 8'h00, `RESP_OKAY);
    watch(3);
    st(2'h2, 1'b1, 1'b0, 1'b0);
    chk(32'(hgood), 32'h0);
    wr(`IDX_HOLD_CTRL, 8'h01, `RESP_OKAY);
    watch(3);
    st(2'h2, 1'b0, 1'b0, 1'b1);
    wr(`IDX_HOLD_CTRL, 8'h00, `RESP_OKAY);
    watch(20);
    fault(4'hF, 4'h0);
    st(2'h2, 1'b0, 1'b1, 1'b0);
    ////////////////////////////////////////////////////////////////////////////////
    wr(`IDX_INPUT_FAULT_MASKS, 8'h00, `RESP_OKAY);
    wr(`IDX_INPUT_RANK_LOW, 8'h12, `RESP_OKAY);
    wr(`IDX_INPUT_RANK_HIGH, 8'h01, `RESP_OKAY);
    wr(`IDX_SWITCH_POLICY_CTRL, 8'h02, `RESP_OKAY);
    fault(4'h0, 4'h0);
    st(2'h1, 1'b1, 1'b0, 1'b0);
    fault(4'h2, 4'h0);
    st(2'h2, 1'b1, 1'b0, 1'b0);
    chk(32'(bcnt), 32'h0);
    fault(4'h0, 4'h0);
    st(2'h1, 1'b1, 1'b0, 1'b0);
    fault(4'h2, 4'h0);
    wr(`IDX_INPUT_FAULT_MASKS, 8'h02, `RESP_OKAY);
    watch(6);
    st(2'h1, 1'b1, 1'b0, 1'b0);
    wr(`IDX_INPUT_FAULT_MASKS, 8'h00, `RESP_OKAY);
    fault(4'h0, 4'h2);
    st(2'h2, 1'b1, 1'b0, 1'b0);
    wr(`IDX_INPUT_FAULT_MASKS, 8'h20, `RESP_OKAY);
    watch(6);
    st(2'h1, 1'b1, 1'b0, 1'b0);
    wr(`IDX_INPUT_FAULT_MASKS, 8'h00, `RESP_OKAY);
    fault(4'h7, 4'h0);
    chk(32'({sel, trk}), 32'({2'h2, 1'b0}));
    wr(`IDX_SWITCH_POLICY_CTRL, 8'h01, `RESP_OKAY);
    fault(4'h0, 4'h0);
    st(2'h2, 1'b1, 1'b0, 1'b0);
    wr(`IDX_MANUAL_SELECT, 8'h00, `RESP_OKAY);
    wr(`IDX_SWITCH_POLICY_CTRL, 8'h03, `RESP_OKAY);
    watch(6);
    st(2'h0, 1'b1, 1'b0, 1'b0);
    ////////////////////////////////////////////////////////////////////////////////
    wr(`IDX_COARSE_MEASURE_LENGTH, 8'h02, `RESP_OKAY);
    wr(`IDX_COARSE_MEASURE_DELAY, 8'h01, `RESP_OKAY);
    wr(`IDX_FINE_MEASURE_LENGTH, 8'h01, `RESP_OKAY);
    wr(`IDX_SWITCH_POLICY_CTRL, 8'h06, `RESP_OKAY);
    watch(20);
    fault(4'h2, 4'h0);
    chk(32'(bcnt), 32'd5);
    st(2'h2, 1'b1, 1'b0, 1'b0);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
